//--- pkg/sbrio_defs.svh
// constants for the subroutine branch, return and port read execution block
`ifndef SBRIO_DEFS_SVH
`define SBRIO_DEFS_SVH
`define SBRIO_PERIODS_PER_CYCLE 2'd3
`define SBRIO_CYC_SHORT         2'd2
`define SBRIO_CYC_LONG          2'd3
`define SBRIO_MASK_ALWAYS       2'd3
`define SBRIO_IDX_REG           2'd3
`define SBRIO_CC_POS            2'b01
`define SBRIO_CC_ZERO           2'b00
`define SBRIO_CC_NEG            2'b10
`define SBRIO_SP_RESET          3'h0
`define SBRIO_II_RESET          1'b0
`define SBRIO_CC_RESET          2'b00
`define SBRIO_IAR_RESET         15'h0000
`define SBRIO_ADDR_MASK         15'h7fff
`define SBRIO_PAGE_MASK         15'h6000
`define SBRIO_OFS_MASK          15'h1fff
`endif

//--- pkg/sbrio_pkg.sv
// types for the subroutine branch, return and port read execution block
package sbrio_pkg;
  typedef enum logic [3:0] {
    SBRIO_OP_NONE        = 4'b0000,
    SBRIO_OP_CALL_FALSE  = 4'b0001,
    SBRIO_OP_CALL_NZ_REL = 4'b0010,
    SBRIO_OP_CALL_NZ_ABS = 4'b0011,
    SBRIO_OP_CALL_IDX    = 4'b0100,
    SBRIO_OP_RET_COND    = 4'b0101,
    SBRIO_OP_RET_IRQ     = 4'b0110,
    SBRIO_OP_RD_DATA     = 4'b0111,
    SBRIO_OP_RD_CTRL     = 4'b1000,
    SBRIO_OP_RD_EXT      = 4'b1001,
    SBRIO_OP_IRQ_CALL    = 4'b1010
  } sbrio_op_t;

  typedef enum logic [2:0] {
    SBRIO_ST_IDLE = 3'b000,
    SBRIO_ST_IND  = 3'b001,
    SBRIO_ST_IO   = 3'b010,
    SBRIO_ST_WAIT = 3'b011,
    SBRIO_ST_DONE = 3'b100
  } sbrio_state_t;
endpackage

//--- logic/sbrio_cycle_div.sv
// divider that marks the end of each three-period processor cycle
`timescale 1ns/1ps
`include "sbrio_defs.svh"
module sbrio_cycle_div (
  input  wire logic clk_in,
  input  wire logic arst_n_in,
  input  wire logic sync_in,
  output logic      cycle_end_out
);
  logic [1:0] cnt_r;
  logic [1:0] cnt_nxt;

  always_comb begin
    if (sync_in || cnt_r == `SBRIO_PERIODS_PER_CYCLE - 2'd1) begin
      cnt_nxt = 2'd0;
    end else begin
      cnt_nxt = cnt_r + 2'd1;
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cnt_r <= 2'd0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  assign cycle_end_out = !sync_in && (cnt_r == `SBRIO_PERIODS_PER_CYCLE - 2'd1);
endmodule

//--- logic/sbrio_exec.sv
// execution of subroutine calls, conditional returns and port reads
`timescale 1ns/1ps
`include "sbrio_defs.svh"
module sbrio_exec (
  input  wire logic                 clk_in,
  input  wire logic                 arst_n_in,
  input  wire logic                 start_in,
  input  wire sbrio_pkg::sbrio_op_t op_in,
  input  wire logic [1:0]           mask_in,
  input  wire logic [7:0]           reg_val_in,
  input  wire logic [7:0]           index_val_in,
  input  wire logic                 indirect_in,
  input  wire logic [14:0]          target_in,
  input  wire logic [14:0]          next_addr_in,
  input  wire logic [7:0]           second_byte_in,
  input  wire logic [14:0]          ind_addr_in,
  input  wire logic                 ind_valid_in,
  input  wire logic [7:0]           data_bus_in,
  output logic                      busy_out,
  output logic                      done_out,
  output logic [14:0]               instruction_address_out,
  output logic [2:0]                stack_pointer_out,
  output logic [1:0]                condition_code_out,
  output logic                      interrupt_inhibit_out,
  output logic [1:0]                index_sel_out,
  output logic                      reg_we_out,
  output logic [7:0]                reg_wdata_out,
  output logic                      ind_req_out,
  output logic [14:0]               ind_ptr_out,
  output logic                      operation_request_strobe_out,
  output logic                      mem_io_sel_out,
  output logic                      read_write_out,
  output logic                      data_control_out,
  output logic                      extended_select_out,
  output logic [7:0]                addr_bus_out
);
  // return address stack, eight entries of flip-flops indexed by the pointer
  logic [14:0]            ras_r [8];
  logic [14:0]            ras_nxt [8];
  logic [14:0]            iar_r, iar_nxt;
  logic [2:0]             sp_r, sp_nxt;
  logic [1:0]             cc_r, cc_nxt;
  logic                   ii_r, ii_nxt;
  logic [1:0]             cc_hold_r, cc_hold_nxt;
  sbrio_pkg::sbrio_op_t   op_r, op_nxt;
  logic [1:0]             mask_r, mask_nxt;
  logic [7:0]             rval_r, rval_nxt;
  logic [7:0]             xval_r, xval_nxt;
  logic                   ind_r, ind_nxt;
  logic [14:0]            tgt_r, tgt_nxt;
  logic [14:0]            ret_r, ret_nxt;
  logic [7:0]             sb_r, sb_nxt;
  logic [1:0]             cyc_r, cyc_nxt;
  sbrio_pkg::sbrio_state_t st_r, st_nxt;
  logic                   we_r, we_nxt;
  logic [7:0]             wd_r, wd_nxt;
  logic                   strobe_r, strobe_nxt;
  logic                   dc_r, dc_nxt;
  logic                   ext_r, ext_nxt;
  logic [7:0]             ab_r, ab_nxt;
  logic                   done_r, done_nxt;
  logic [7:0]             bus_s1_r, bus_s2_r;
  logic                   cyc_end;
  logic                   is_call, is_ret, is_read, taken;
  logic [1:0]             cyc_need;
  logic [14:0]            ea;
  logic [2:0]             sp_up;

  sbrio_cycle_div u_div (
    .clk_in        (clk_in),
    .arst_n_in     (arst_n_in),
    .sync_in       (start_in && st_r == sbrio_pkg::SBRIO_ST_IDLE),
    .cycle_end_out (cyc_end)
  );

  // data bus comes from the pins, so it is synchronised before use
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      bus_s1_r <= 8'h00;
      bus_s2_r <= 8'h00;
    end else begin
      bus_s1_r <= data_bus_in;
      bus_s2_r <= bus_s1_r;
    end
  end

  always_comb begin
    is_call = op_r inside {sbrio_pkg::SBRIO_OP_CALL_FALSE, sbrio_pkg::SBRIO_OP_CALL_NZ_REL,
                           sbrio_pkg::SBRIO_OP_CALL_NZ_ABS, sbrio_pkg::SBRIO_OP_CALL_IDX,
                           sbrio_pkg::SBRIO_OP_IRQ_CALL};
    is_ret  = op_r inside {sbrio_pkg::SBRIO_OP_RET_COND, sbrio_pkg::SBRIO_OP_RET_IRQ};
    is_read = op_r inside {sbrio_pkg::SBRIO_OP_RD_DATA, sbrio_pkg::SBRIO_OP_RD_CTRL,
                           sbrio_pkg::SBRIO_OP_RD_EXT};
    case (op_r)
      sbrio_pkg::SBRIO_OP_CALL_FALSE:  taken = (mask_r != cc_hold_r);
      sbrio_pkg::SBRIO_OP_CALL_NZ_REL: taken = (rval_r != 8'h00);
      sbrio_pkg::SBRIO_OP_CALL_NZ_ABS: taken = (rval_r != 8'h00);
      sbrio_pkg::SBRIO_OP_CALL_IDX:    taken = 1'b1;
      sbrio_pkg::SBRIO_OP_IRQ_CALL:    taken = 1'b1;
      sbrio_pkg::SBRIO_OP_RET_COND,
      sbrio_pkg::SBRIO_OP_RET_IRQ:
        taken = (mask_r == `SBRIO_MASK_ALWAYS) || (mask_r == cc_hold_r);
      default:                         taken = 1'b0;
    endcase
    cyc_need = (op_r == sbrio_pkg::SBRIO_OP_RD_DATA || op_r == sbrio_pkg::SBRIO_OP_RD_CTRL)
             ? `SBRIO_CYC_SHORT : `SBRIO_CYC_LONG;
    // indexed call adds register 3 after any indirection
    if (op_r == sbrio_pkg::SBRIO_OP_CALL_IDX) begin
      ea = (tgt_r + {7'h00, xval_r}) & `SBRIO_ADDR_MASK;
    end else begin
      ea = tgt_r;
    end
    sp_up = sp_r + 3'd1;
  end

  always_comb begin
    st_nxt      = st_r;
    op_nxt      = op_r;
    mask_nxt    = mask_r;
    rval_nxt    = rval_r;
    xval_nxt    = xval_r;
    ind_nxt     = ind_r;
    tgt_nxt     = tgt_r;
    ret_nxt     = ret_r;
    sb_nxt      = sb_r;
    cyc_nxt     = cyc_r;
    cc_hold_nxt = cc_hold_r;
    iar_nxt     = iar_r;
    sp_nxt      = sp_r;
    cc_nxt      = cc_r;
    ii_nxt      = ii_r;
    we_nxt      = 1'b0;
    wd_nxt      = wd_r;
    strobe_nxt  = 1'b0;
    dc_nxt      = dc_r;
    ext_nxt     = ext_r;
    ab_nxt      = ab_r;
    done_nxt    = 1'b0;
    for (int i = 0; i < 8; i++) begin
      ras_nxt[i] = ras_r[i];
    end
    case (st_r)
      sbrio_pkg::SBRIO_ST_IDLE: begin
        if (start_in) begin
          // a false call with mask 3 is the indexed unconditional call
          if (op_in == sbrio_pkg::SBRIO_OP_CALL_FALSE && mask_in == `SBRIO_MASK_ALWAYS) begin
            op_nxt = sbrio_pkg::SBRIO_OP_CALL_IDX;
          end else begin
            op_nxt = op_in;
          end
          mask_nxt    = mask_in;
          rval_nxt    = reg_val_in;
          xval_nxt    = index_val_in;
          ind_nxt     = indirect_in;
          tgt_nxt     = target_in;
          ret_nxt     = next_addr_in;
          sb_nxt      = second_byte_in;
          cc_hold_nxt = cc_r;
          cyc_nxt     = 2'd0;
          st_nxt      = sbrio_pkg::SBRIO_ST_WAIT;
        end
      end
      sbrio_pkg::SBRIO_ST_WAIT: begin
        if (cyc_end) begin
          cyc_nxt = cyc_r + 2'd1;
          if (cyc_r == 2'd0) begin
            if (is_call && ind_r && taken) begin
              st_nxt = sbrio_pkg::SBRIO_ST_IND;
            end else if (is_read) begin
              // strobe rises with the io cycle so the two-flop bus copy is valid at its end
              st_nxt     = sbrio_pkg::SBRIO_ST_IO;
              strobe_nxt = 1'b1;
              dc_nxt     = (op_r != sbrio_pkg::SBRIO_OP_RD_CTRL);
              ext_nxt    = (op_r == sbrio_pkg::SBRIO_OP_RD_EXT);
              ab_nxt     = (op_r == sbrio_pkg::SBRIO_OP_RD_EXT) ? sb_r : 8'h00;
            end
          end else if (cyc_r == cyc_need - 2'd1) begin
            st_nxt = sbrio_pkg::SBRIO_ST_DONE;
          end
        end
      end
      sbrio_pkg::SBRIO_ST_IND: begin
        // stay until memory returns the indirect address; cycle count stretches
        if (ind_valid_in) begin
          tgt_nxt = ind_addr_in & `SBRIO_ADDR_MASK;
          ind_nxt = 1'b0;
          st_nxt  = sbrio_pkg::SBRIO_ST_WAIT;
        end
      end
      sbrio_pkg::SBRIO_ST_IO: begin
        strobe_nxt = 1'b1;
        dc_nxt     = (op_r != sbrio_pkg::SBRIO_OP_RD_CTRL);
        ext_nxt    = (op_r == sbrio_pkg::SBRIO_OP_RD_EXT);
        ab_nxt     = (op_r == sbrio_pkg::SBRIO_OP_RD_EXT) ? sb_r : 8'h00;
        if (cyc_end) begin
          strobe_nxt = 1'b0;
          cyc_nxt    = cyc_r + 2'd1;
          we_nxt     = 1'b1;
          wd_nxt     = bus_s2_r;
          if (bus_s2_r == 8'h00) begin
            cc_nxt = `SBRIO_CC_ZERO;
          end else if (bus_s2_r[7]) begin
            cc_nxt = `SBRIO_CC_NEG;
          end else begin
            cc_nxt = `SBRIO_CC_POS;
          end
          st_nxt = (cyc_r == cyc_need - 2'd1) ? sbrio_pkg::SBRIO_ST_DONE
                                             : sbrio_pkg::SBRIO_ST_WAIT;
        end
      end
      sbrio_pkg::SBRIO_ST_DONE: begin
        done_nxt = 1'b1;
        st_nxt   = sbrio_pkg::SBRIO_ST_IDLE;
        if (is_call && taken) begin
          sp_nxt          = sp_up;
          ras_nxt[sp_up]  = ret_r;
          iar_nxt         = ea;
          if (op_r == sbrio_pkg::SBRIO_OP_IRQ_CALL) begin
            ii_nxt = 1'b1;
          end
        end else if (is_ret && taken) begin
          iar_nxt = ras_r[sp_r];
          sp_nxt  = sp_r - 3'd1;
          if (op_r == sbrio_pkg::SBRIO_OP_RET_IRQ) begin
            ii_nxt = 1'b0;
          end
        end else begin
          iar_nxt = ret_r;
        end
      end
      default: st_nxt = sbrio_pkg::SBRIO_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st_r      <= sbrio_pkg::SBRIO_ST_IDLE;
      op_r      <= sbrio_pkg::SBRIO_OP_NONE;
      mask_r    <= 2'b00;
      rval_r    <= 8'h00;
      xval_r    <= 8'h00;
      ind_r     <= 1'b0;
      tgt_r     <= `SBRIO_IAR_RESET;
      ret_r     <= `SBRIO_IAR_RESET;
      sb_r      <= 8'h00;
      cyc_r     <= 2'd0;
      cc_hold_r <= `SBRIO_CC_RESET;
      iar_r     <= `SBRIO_IAR_RESET;
      sp_r      <= `SBRIO_SP_RESET;
      cc_r      <= `SBRIO_CC_RESET;
      ii_r      <= `SBRIO_II_RESET;
      we_r      <= 1'b0;
      wd_r      <= 8'h00;
      strobe_r  <= 1'b0;
      dc_r      <= 1'b1;
      ext_r     <= 1'b0;
      ab_r      <= 8'h00;
      done_r    <= 1'b0;
      for (int i = 0; i < 8; i++) begin
        ras_r[i] <= `SBRIO_IAR_RESET;
      end
    end else begin
      st_r      <= st_nxt;
      op_r      <= op_nxt;
      mask_r    <= mask_nxt;
      rval_r    <= rval_nxt;
      xval_r    <= xval_nxt;
      ind_r     <= ind_nxt;
      tgt_r     <= tgt_nxt;
      ret_r     <= ret_nxt;
      sb_r      <= sb_nxt;
      cyc_r     <= cyc_nxt;
      cc_hold_r <= cc_hold_nxt;
      iar_r     <= iar_nxt;
      sp_r      <= sp_nxt;
      cc_r      <= cc_nxt;
      ii_r      <= ii_nxt;
      we_r      <= we_nxt;
      wd_r      <= wd_nxt;
      strobe_r  <= strobe_nxt;
      dc_r      <= dc_nxt;
      ext_r     <= ext_nxt;
      ab_r      <= ab_nxt;
      done_r    <= done_nxt;
      for (int i = 0; i < 8; i++) begin
        ras_r[i] <= ras_nxt[i];
      end
    end
  end

  assign busy_out                     = (st_r != sbrio_pkg::SBRIO_ST_IDLE);
  assign done_out                     = done_r;
  assign instruction_address_out      = iar_r;
  assign stack_pointer_out            = sp_r;
  assign condition_code_out           = cc_r;
  assign interrupt_inhibit_out        = ii_r;
  assign index_sel_out                = `SBRIO_IDX_REG;
  assign reg_we_out                   = we_r;
  assign reg_wdata_out                = wd_r;
  assign ind_req_out                  = (st_r == sbrio_pkg::SBRIO_ST_IND);
  assign ind_ptr_out                  = tgt_r;
  assign operation_request_strobe_out = strobe_r;
  // while strobing a read, memory/io selects io and read/write selects read
  assign mem_io_sel_out               = !strobe_r;
  assign read_write_out               = !strobe_r;
  assign data_control_out             = dc_r;
  assign extended_select_out          = ext_r;
  assign addr_bus_out                 = ab_r;
endmodule

//--- tb/sbrio_io_model.sv
// behavioural peripheral answering port reads on the data bus
`timescale 1ns/1ps
module sbrio_io_model (
  input  wire logic       clk_in,
  input  wire logic       strobe_in,
  input  wire logic       ext_in,
  input  wire logic       dc_in,
  input  wire logic [7:0] dval_in,
  input  wire logic [7:0] cval_in,
  input  wire logic [7:0] eval_in,
  output logic      [7:0] data_out
);
  logic [7:0] last_r = 8'h00;
  logic [7:0] drv;
  assign drv = ext_in ? eval_in : (dc_in ? dval_in : cval_in);
  // released bus shows the inverse of the last byte, so a late sample cannot pass by luck
  assign data_out = strobe_in ? drv : ~last_r;
  always_ff @(posedge clk_in) begin
    if (strobe_in) begin
      last_r <= drv;
    end
  end
endmodule

//--- tb/sbrio_exec_checker.sv
// assertions on the ports of the call, return and port read block
`timescale 1ns/1ps
module sbrio_exec_checker (
  input wire logic                 clk_in,
  input wire logic                 arst_n_in,
  input wire logic                 start_in,
  input wire sbrio_pkg::sbrio_op_t op_in,
  input wire logic                 indirect_in,
  input wire logic                 busy_out,
  input wire logic                 done_out,
  input wire logic [2:0]           stack_pointer_out,
  input wire logic [1:0]           condition_code_out,
  input wire logic                 interrupt_inhibit_out,
  input wire logic [1:0]           index_sel_out,
  input wire logic                 reg_we_out,
  input wire logic [7:0]           reg_wdata_out,
  input wire logic                 operation_request_strobe_out,
  input wire logic                 mem_io_sel_out,
  input wire logic                 read_write_out,
  input wire logic                 data_control_out,
  input wire logic                 extended_select_out
);
  sbrio_pkg::sbrio_op_t op_q;
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      op_q <= sbrio_pkg::SBRIO_OP_NONE;
    end else if (start_in && !busy_out) begin
      op_q <= op_in;
    end
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  a_io_read_quals: assert property (
    operation_request_strobe_out |-> !mem_io_sel_out && !read_write_out)
    else $error("strobe without io read qualifiers");
  a_strobe_in_op: assert property (operation_request_strobe_out |-> busy_out)
    else $error("strobe outside an instruction");
  a_ctrl_select: assert property (
    operation_request_strobe_out && !data_control_out |-> op_q == sbrio_pkg::SBRIO_OP_RD_CTRL)
    else $error("control select on wrong operation");
  a_ext_select: assert property (
    operation_request_strobe_out && extended_select_out |-> op_q == sbrio_pkg::SBRIO_OP_RD_EXT)
    else $error("extended select on wrong operation");
  a_index_reg: assert property (index_sel_out == 2'h3)
    else $error("index register not three");
  a_cc_follows: assert property (reg_we_out |-> condition_code_out ==
    ((reg_wdata_out == 8'h00) ? 2'b00 : (reg_wdata_out[7] ? 2'b10 : 2'b01)))
    else $error("condition code does not match loaded byte");
  a_we_single: assert property (reg_we_out |=> !reg_we_out)
    else $error("register write longer than one cycle");
  a_sp_step: assert property (
    stack_pointer_out != $past(stack_pointer_out) |-> done_out &&
    (stack_pointer_out - $past(stack_pointer_out) == 3'h1 ||
     $past(stack_pointer_out) - stack_pointer_out == 3'h1))
    else $error("stack pointer moved by other than one");
  a_ii_set: assert property (
    $rose(interrupt_inhibit_out) |-> done_out && op_q == sbrio_pkg::SBRIO_OP_IRQ_CALL)
    else $error("inhibit set outside interrupt call");
  a_ii_clear: assert property (
    $fell(interrupt_inhibit_out) |-> done_out && op_q == sbrio_pkg::SBRIO_OP_RET_IRQ)
    else $error("inhibit cleared outside irq return");
  a_read_time: assert property (start_in && !busy_out &&
    (op_in == sbrio_pkg::SBRIO_OP_RD_DATA || op_in == sbrio_pkg::SBRIO_OP_RD_CTRL)
    |=> !done_out [*5] ##[1:4] done_out)
    else $error("short read took wrong time");
  a_long_time: assert property (start_in && !busy_out && !indirect_in &&
    op_in inside {[sbrio_pkg::SBRIO_OP_CALL_FALSE:sbrio_pkg::SBRIO_OP_RET_IRQ],
    sbrio_pkg::SBRIO_OP_RD_EXT} |=> !done_out [*8] ##[1:6] done_out)
    else $error("three cycle operation took wrong time");
endmodule
bind sbrio_exec sbrio_exec_checker u_chk (.*);

//--- tb/tb.sv
// self-checking bench for the call, return and port read block
`timescale 1ns/1ps
module tb;
  logic                 clk_in         = 1'b0;
  logic                 arst_n_in      = 1'b0;
  logic                 start_in       = 1'b0;
  sbrio_pkg::sbrio_op_t op_in          = sbrio_pkg::SBRIO_OP_NONE;
  logic [1:0]           mask_in        = 2'h0;
  logic [7:0]           reg_val_in     = 8'h00;
  logic [7:0]           index_val_in   = 8'h21;
  logic                 indirect_in    = 1'b0;
  logic [14:0]          target_in      = 15'h0000;
  logic [14:0]          next_addr_in   = 15'h0000;
  logic [7:0]           second_byte_in = 8'h00;
  logic [14:0]          ind_addr_in    = 15'h0000;
  logic                 ind_valid_in   = 1'b0;
  logic [7:0]           data_bus_in;
  logic                 busy_out, done_out, interrupt_inhibit_out, reg_we_out, ind_req_out;
  logic                 operation_request_strobe_out, mem_io_sel_out, read_write_out;
  logic                 data_control_out, extended_select_out;
  logic [14:0]          instruction_address_out, ind_ptr_out;
  logic [2:0]           stack_pointer_out;
  logic [1:0]           condition_code_out, index_sel_out;
  logic [7:0]           reg_wdata_out, addr_bus_out;
  logic [7:0]           pd, pc, pe, s_adr;
  logic                 s_hit, s_dc, s_ext;
  logic [14:0]          stk [8];
  logic [2:0]           esp = 3'h0;
  int                   err_count = 0;
  int                   compares = 0;
  int                   ncyc, k = 0;

  sbrio_exec u_dut (.*);
  sbrio_io_model u_io (.clk_in(clk_in), .strobe_in(operation_request_strobe_out),
    .ext_in(extended_select_out), .dc_in(data_control_out), .dval_in(pd), .cval_in(pc),
    .eval_in(pe), .data_out(data_bus_in));

  initial begin
    forever #12.5 clk_in = ~clk_in;
  end

  // memory holds at each pointer the pointer plus an offset of 15'h0100
  always @(posedge clk_in) begin
    ind_valid_in <= ind_req_out;
    ind_addr_in <= ind_ptr_out + 15'h0100;
  end

  function automatic logic [1:0] ccf(input logic [7:0] v);
    return (v == 8'h00) ? 2'b00 : (v[7] ? 2'b10 : 2'b01);
  endfunction

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic stop_test();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic run(input sbrio_pkg::sbrio_op_t op, input logic [1:0] m,
                     input logic [7:0] r, input logic ind);
    op_in <= op;
    mask_in <= m;
    reg_val_in <= r;
    indirect_in <= ind;
    start_in <= 1'b1;
    @(posedge clk_in);
    #1;
    start_in <= 1'b0;
    ncyc = 0;
    s_hit = 1'b0;
    while (done_out !== 1'b1) begin
      @(posedge clk_in);
      #1;
      ncyc++;
      if (operation_request_strobe_out === 1'b1) begin
        s_hit = 1'b1;
        s_dc = data_control_out;
        s_ext = extended_select_out;
        s_adr = addr_bus_out;
      end
      if (ncyc > 80) begin
        err_count++;
        $display("[ERR] done expected 1 seen 0");
        stop_test();
      end
    end
  endtask

  task automatic rd(input sbrio_pkg::sbrio_op_t op, input logic [7:0] v);
    logic ext;
    ext = (op == sbrio_pkg::SBRIO_OP_RD_EXT);
    pd = (op == sbrio_pkg::SBRIO_OP_RD_DATA) ? v : ~v;
    pc = (op == sbrio_pkg::SBRIO_OP_RD_CTRL) ? v : ~v;
    pe = ext ? v : ~v;
    second_byte_in <= v ^ 8'h5a;
    run(op, 2'h0, 8'h00, 1'b0);
    chk("reg_wdata", 16'(v), 16'(reg_wdata_out));
    chk("cc", 16'(ccf(v)), 16'(condition_code_out));
    chk("strobe_seen", 16'h1, 16'(s_hit));
    chk("ext_sel", 16'(ext), 16'(s_ext));
    if (!ext) chk("dc_sel", 16'(op == sbrio_pkg::SBRIO_OP_RD_DATA), 16'(s_dc));
    if (ext) chk("addr_bus", 16'(v ^ 8'h5a), 16'(s_adr));
    chk("min_clocks", 16'h1, 16'(ncyc >= (ext ? 9 : 6)));
    $display("read test %s done", op.name());
  endtask

  // kind 0 falls through, 1 pushes and jumps, 2 pops
  task automatic step(input sbrio_pkg::sbrio_op_t op, input logic [1:0] m, input logic [7:0] r,
                      input logic ind, input logic [1:0] kind, input logic eii);
    logic [14:0] t, n, ea, ex;
    k++;
    t = 15'h1000 + 15'(k * 17);
    n = 15'h0200 + 15'(k);
    target_in <= t;
    next_addr_in <= n;
    ea = t + (ind ? 15'h0100 : 15'h0000);
    if (op == sbrio_pkg::SBRIO_OP_CALL_IDX || (op == sbrio_pkg::SBRIO_OP_CALL_FALSE && m == 2'h3))
      ea = ea + 15'(index_val_in);
    run(op, m, r, ind);
    ex = n;
    if (kind == 2'd1) begin
      esp = esp + 3'h1;
      stk[esp] = n;
      ex = ea;
    end else if (kind == 2'd2) begin
      ex = stk[esp];
      esp = esp - 3'h1;
    end
    chk("iar", 16'(ex), 16'(instruction_address_out));
    chk("sp", 16'(esp), 16'(stack_pointer_out));
    chk("ii", 16'(eii), 16'(interrupt_inhibit_out));
    chk("min_clocks", 16'h1, 16'(ncyc >= 9));
    $display("step test %0d done", k);
  endtask

  initial begin
    repeat (6) @(posedge clk_in);
    arst_n_in <= 1'b1;
    @(posedge clk_in);
    #1;
    chk("rst_sp", 16'h0, 16'(stack_pointer_out));
    chk("rst_idx_sel", 16'h3, 16'(index_sel_out));
    rd(sbrio_pkg::SBRIO_OP_RD_DATA, 8'h35);
    rd(sbrio_pkg::SBRIO_OP_RD_CTRL, 8'h00);
    rd(sbrio_pkg::SBRIO_OP_RD_DATA, 8'h9c);
    rd(sbrio_pkg::SBRIO_OP_RD_CTRL, 8'h7f);
    rd(sbrio_pkg::SBRIO_OP_RD_EXT, 8'hc3);
    step(sbrio_pkg::SBRIO_OP_CALL_FALSE, 2'h2, 8'h00, 1'b0, 2'd0, 1'b0);
    step(sbrio_pkg::SBRIO_OP_CALL_FALSE, 2'h1, 8'h00, 1'b0, 2'd1, 1'b0);
    step(sbrio_pkg::SBRIO_OP_CALL_FALSE, 2'h3, 8'h00, 1'b0, 2'd1, 1'b0);
    step(sbrio_pkg::SBRIO_OP_CALL_NZ_REL, 2'h0, 8'h00, 1'b0, 2'd0, 1'b0);
    step(sbrio_pkg::SBRIO_OP_CALL_NZ_REL, 2'h0, 8'h01, 1'b0, 2'd1, 1'b0);
    step(sbrio_pkg::SBRIO_OP_CALL_NZ_ABS, 2'h0, 8'h00, 1'b0, 2'd0, 1'b0);
    step(sbrio_pkg::SBRIO_OP_CALL_NZ_ABS, 2'h0, 8'h80, 1'b1, 2'd1, 1'b0);
    step(sbrio_pkg::SBRIO_OP_CALL_IDX, 2'h0, 8'h00, 1'b1, 2'd1, 1'b0);
    step(sbrio_pkg::SBRIO_OP_RET_COND, 2'h0, 8'h00, 1'b0, 2'd0, 1'b0);
    step(sbrio_pkg::SBRIO_OP_RET_COND, 2'h2, 8'h00, 1'b0, 2'd2, 1'b0);
    step(sbrio_pkg::SBRIO_OP_RET_COND, 2'h3, 8'h00, 1'b0, 2'd2, 1'b0);
    step(sbrio_pkg::SBRIO_OP_IRQ_CALL, 2'h0, 8'h00, 1'b0, 2'd1, 1'b1);
    step(sbrio_pkg::SBRIO_OP_RET_IRQ, 2'h1, 8'h00, 1'b0, 2'd0, 1'b1);
    step(sbrio_pkg::SBRIO_OP_RET_IRQ, 2'h3, 8'h00, 1'b0, 2'd2, 1'b0);
    stop_test();
  end
endmodule
